// ==== design/ascg_top.v ====
// audio sample clock generator: divides a master clock into base,
// adc and dac sample strobes, with bypass divider or fractional pll
// assumes master clock is sampled on CLK, which runs far faster
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "ascg_defines.vh"

module ascg_top (
    // clock, reset, enable
    input wire CLK,
    input wire SYS_RST,
    input wire CE,
    // register port
    input wire [7:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [15:0] RDATA,
    // clock pins
    input wire MCLK_IN,
    input wire BCLK_IN,
    // sample strobes, clocks and control and status outputs
    output reg BASE_TICK,
    output reg DAC_TICK,
    output reg ADC_TICK,
    output reg DAC_OSR_TICK,
    output reg ADC_WORD_CLOCK_PIN,
    output reg WORD_CLOCK,
    output reg ADC_WCLK_SEP,
    output reg MONITOR_PIN,
    output reg MONITOR_OE,
    output reg REF_RATE_SELECT,
    output reg TSC_EXT_CLK,
    output reg OSC_POWER
);
    reg [15:0] rate_q, ctrl3_q, pll1_q, pll2_q, mon_q, clkctl_q;
    reg [2:0] mclk_s;
    reg [1:0] bclk_s;
    reg [31:0] acc_q;
    reg [10:0] pre_q;
    reg [4:0] qcnt_q;
    reg [2:0] pcnt_q;
    reg pll_ck_q;
    reg [7:0] dac_ph_q, adc_ph_q;
    reg [6:0] osr_q;
    reg dac_ws_q, adc_ws_q;
    wire mclk_rise = mclk_s[1] & ~mclk_s[2];
    wire conv_on = clkctl_q[`ASCG_ADC_PWR_BIT] |
        clkctl_q[`ASCG_DAC_PWR_BIT];
    wire pll_en = pll1_q[`ASCG_PLL_EN_BIT];
    wire [2:0] dac_sel = rate_q[`ASCG_DAC_SEL_HI:`ASCG_DAC_SEL_LO];
    wire [2:0] adc_sel = rate_q[`ASCG_ADC_SEL_HI:`ASCG_ADC_SEL_LO];
    wire [4:0] q_raw = clkctl_q[`ASCG_Q_HI:`ASCG_Q_LO];
    wire [4:0] q_div = (q_raw < `ASCG_Q_MIN) ? `ASCG_Q_MIN :
        ((q_raw > `ASCG_Q_MAX) ? `ASCG_Q_MAX : q_raw);
    wire [2:0] p_code = pll1_q[`ASCG_P_HI:`ASCG_P_LO];
    wire [5:0] j_raw = pll1_q[`ASCG_J_HI:`ASCG_J_LO];
    wire [5:0] j_val = (j_raw < `ASCG_J_MIN) ? `ASCG_J_MIN : j_raw;
    wire [13:0] d_raw = pll2_q[`ASCG_D_HI:`ASCG_D_LO];
    wire [13:0] d_val = (d_raw > `ASCG_D_MAX) ? `ASCG_D_MAX : d_raw;
    // pll step per P-divided master edge, in 1/10000 units
    wire [31:0] k_step = j_val * `ASCG_FRAC_BASE + d_val;
    wire [31:0] acc_lim = `ASCG_PLL_PRE * `ASCG_FRAC_BASE;
    wire [32:0] acc_sum = {1'b0, acc_q} + {1'b0, k_step};
    wire p_edge = mclk_rise && (pcnt_q == p_code);
    wire base_ev = pll_en ? (p_edge && (acc_sum >= {1'b0, acc_lim}))
        : (mclk_rise && qcnt_q == q_div - 5'h01 &&
           pre_q == `ASCG_BYPASS_PRE - 1);
    // osr tick divides base period by 128 by direct divider count in bypass; in pll mode it marks accumulator scale crossings, at most one per P-divided edge
    wire osr_ev = pll_en ? (p_edge &&
        (acc_sum[31:0] / (acc_lim / `ASCG_DAC_OSR)) !=
        (acc_q / (acc_lim / `ASCG_DAC_OSR)))
        : (mclk_rise && qcnt_q == q_div - 5'h01);
    // accumulator after this step, wrapped at the base period
    wire [31:0] acc_half = acc_lim >> 1;
    wire [31:0] acc_nxt = (acc_sum >= {1'b0, acc_lim}) ?
        acc_sum[31:0] - acc_lim : acc_sum[31:0];
    // mid-period half step: accumulator crossing in pll mode,
    // osr count 63 in bypass; osr ticks are too coarse in pll mode
    wire half_ev = pll_en ? (p_edge && (acc_q < acc_half) &&
        (acc_nxt >= acc_half)) : (osr_ev && osr_q == 7'h3F);

    // half-periods of base ticks per divider code 1,1.5,2,3,4,5,5.5,6
    function [7:0] half_count;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: half_count = 8'h02;
                3'h1: half_count = 8'h03;
                3'h2: half_count = 8'h04;
                3'h3: half_count = 8'h06;
                3'h4: half_count = 8'h08;
                3'h5: half_count = 8'h0A;
                3'h6: half_count = 8'h0B;
                default: half_count = 8'h0C;
            endcase
        end
    endfunction

    function [15:0] reg_read;
        input [7:0] a;
        begin
            case (a)
                `ASCG_IDX_RATE: reg_read = rate_q;
                `ASCG_IDX_CTRL3: reg_read = ctrl3_q;
                `ASCG_IDX_PLL1: reg_read = pll1_q;
                `ASCG_IDX_PLL2: reg_read = pll2_q;
                `ASCG_IDX_MON: reg_read = mon_q;
                `ASCG_IDX_CLKCTL: reg_read = clkctl_q;
                `ASCG_IDX_STAT: reg_read = {12'h000, ADC_WCLK_SEP,
                    pll_en, OSC_POWER, TSC_EXT_CLK};
                default: reg_read = 16'h0000;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rate_q <= `ASCG_RST_RATE;
            ctrl3_q <= `ASCG_RST_CTRL3;
            pll1_q <= `ASCG_RST_PLL1;
            pll2_q <= `ASCG_RST_PLL2;
            mon_q <= `ASCG_RST_MON;
            clkctl_q <= `ASCG_RST_CLKCTL;
            RDATA <= 16'h0000;
        end else if (CE) begin
            RDATA <= RD ? reg_read(ADDR) : 16'h0000;
            if (WR) begin
                case (ADDR)
                    `ASCG_IDX_RATE: rate_q <= WDATA;
                    `ASCG_IDX_CTRL3: ctrl3_q <= WDATA;
                    `ASCG_IDX_PLL1: pll1_q <= WDATA;
                    `ASCG_IDX_PLL2: pll2_q <= WDATA;
                    `ASCG_IDX_MON: mon_q <= WDATA;
                    `ASCG_IDX_CLKCTL: clkctl_q <= WDATA;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // master clock sampling and base rate generation
    // ------------------------------------------------------------
    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mclk_s <= 3'h0;
            bclk_s <= 2'h0;
            acc_q <= 32'h00000000;
            pre_q <= 11'h000;
            qcnt_q <= 5'h00;
            pcnt_q <= 3'h0;
            pll_ck_q <= 1'b0;
        end else if (CE) begin
            mclk_s <= {mclk_s[1:0], MCLK_IN};
            bclk_s <= {bclk_s[0], BCLK_IN};
            if (!conv_on) begin
                acc_q <= 32'h00000000;
                pre_q <= 11'h000;
                qcnt_q <= 5'h00;
                pcnt_q <= 3'h0;
            end else if (mclk_rise) begin
                if (pll_en) begin
                    // fractional multiply then divide by 2048 * P
                    pcnt_q <= (pcnt_q == p_code) ? 3'h0 :
                        pcnt_q + 3'h1;
                    if (p_edge) begin
                        acc_q <= acc_nxt;
                        // high in the upper half of the period
                        pll_ck_q <= (acc_nxt >= acc_half);
                    end
                end else begin
                    // divide by direct divider then by 128
                    if (qcnt_q >= q_div - 5'h01) begin
                        qcnt_q <= 5'h00;
                        pre_q <= (pre_q == `ASCG_BYPASS_PRE - 1) ?
                            11'h000 : pre_q + 11'h001;
                    end else begin
                        qcnt_q <= qcnt_q + 5'h01;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // rate dividers, oversampling and pin outputs
    // ------------------------------------------------------------
    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dac_ph_q <= 8'h00;
            adc_ph_q <= 8'h00;
            osr_q <= 7'h00;
            dac_ws_q <= 1'b0;
            adc_ws_q <= 1'b0;
            BASE_TICK <= 1'b0;
            DAC_TICK <= 1'b0;
            ADC_TICK <= 1'b0;
            DAC_OSR_TICK <= 1'b0;
            ADC_WORD_CLOCK_PIN <= 1'b0;
            WORD_CLOCK <= 1'b0;
            ADC_WCLK_SEP <= 1'b0;
            MONITOR_PIN <= 1'b0;
            MONITOR_OE <= 1'b0;
            REF_RATE_SELECT <= 1'b0;
            TSC_EXT_CLK <= 1'b0;
            OSC_POWER <= 1'b1;
        end else if (CE) begin
            BASE_TICK <= conv_on && base_ev;
            DAC_OSR_TICK <= conv_on && osr_ev;
            DAC_TICK <= 1'b0;
            ADC_TICK <= 1'b0;
            if (!conv_on) begin
                dac_ph_q <= 8'h00;
                adc_ph_q <= 8'h00;
                osr_q <= 7'h00;
            end else begin
                if (osr_ev)
                    osr_q <= osr_q + 7'h01;
                // two phase ticks per base period give half steps
                if (base_ev || half_ev) begin
                    if (dac_ph_q >= half_count(dac_sel) - 8'h01) begin
                        dac_ph_q <= 8'h00;
                        DAC_TICK <= 1'b1;
                        dac_ws_q <= ~dac_ws_q;
                    end else begin
                        dac_ph_q <= dac_ph_q + 8'h01;
                    end
                    if (adc_ph_q >= half_count(adc_sel) - 8'h01) begin
                        adc_ph_q <= 8'h00;
                        ADC_TICK <= 1'b1;
                        adc_ws_q <= ~adc_ws_q;
                    end else begin
                        adc_ph_q <= adc_ph_q + 8'h01;
                    end
                end
            end
            ADC_WCLK_SEP <= (dac_sel != adc_sel);
            WORD_CLOCK <= dac_ws_q;
            ADC_WORD_CLOCK_PIN <= (dac_sel != adc_sel) ? adc_ws_q :
                1'b0;
            REF_RATE_SELECT <= ctrl3_q[`ASCG_REF_SEL_BIT];
            TSC_EXT_CLK <= conv_on & bclk_s[1];
            OSC_POWER <= ~conv_on;
            MONITOR_OE <= mon_q[`ASCG_MON_EN_BIT];
            MONITOR_PIN <= mon_q[`ASCG_MON_EN_BIT] && pll_en &&
                conv_on && pll_ck_q;
        end
    end
endmodule

// ==== common/ascg_defines.vh ====
// constants for the audio sample clock generator
// assumes inclusion by its bare name from the design file
`ifndef ASCG_DEFINES_VH
`define ASCG_DEFINES_VH
// register indices, byte address is four times the index
`define ASCG_IDX_RATE 8'h00
`define ASCG_IDX_CTRL3 8'h06
`define ASCG_IDX_PLL1 8'h1B
`define ASCG_IDX_PLL2 8'h1C
`define ASCG_IDX_MON 8'h22
`define ASCG_IDX_CLKCTL 8'h30
`define ASCG_IDX_STAT 8'h31
// rate register fields
`define ASCG_DAC_SEL_LO 3
`define ASCG_DAC_SEL_HI 5
`define ASCG_ADC_SEL_LO 0
`define ASCG_ADC_SEL_HI 2
// control 3 field
`define ASCG_REF_SEL_BIT 13
// pll register 1: enable, ref divider code, integer part
`define ASCG_PLL_EN_BIT 15
`define ASCG_P_LO 8
`define ASCG_P_HI 10
`define ASCG_J_LO 2
`define ASCG_J_HI 7
// pll register 2: fraction in bits 15..2
`define ASCG_D_LO 2
`define ASCG_D_HI 15
// monitor register
`define ASCG_MON_EN_BIT 2
// clock control register: direct divider, adc and dac power
`define ASCG_Q_LO 0
`define ASCG_Q_HI 4
`define ASCG_ADC_PWR_BIT 8
`define ASCG_DAC_PWR_BIT 9
// reset values
`define ASCG_RST_RATE 16'h0000
`define ASCG_RST_CTRL3 16'h0000
`define ASCG_RST_PLL1 16'h1004
`define ASCG_RST_PLL2 16'h0000
`define ASCG_RST_MON 16'h0000
`define ASCG_RST_CLKCTL 16'h0002
// limits
`define ASCG_Q_MIN 5'h02
`define ASCG_Q_MAX 5'h11
`define ASCG_J_MIN 6'h01
`define ASCG_D_MAX 14'h270F
`define ASCG_BYPASS_PRE 128
`define ASCG_PLL_PRE 2048
`define ASCG_FRAC_BASE 10000
`define ASCG_DAC_OSR 128
`endif

// ==== testbench/ascg_mclk_model.sv ====
// master clock and bit clock source driving the clock generator
// assumes both clocks run free; edges never meet a CLK rising edge
`timescale 1ns/10ps
module ascg_mclk_model #(
    parameter MCLK_HALF = 200,
    parameter BCLK_HALF = 332
) (
    // clocks
    output logic mclk,
    output logic bclk
);
    initial begin
        mclk = 1'b0;
        bclk = 1'b0;
    end
    // master clock keeps running while converters work
    always #(MCLK_HALF) mclk = ~mclk;
    always #(BCLK_HALF) bclk = ~bclk;
endmodule

// ==== testbench/ascg_chk.sv ====
// port assertions for the audio sample clock generator
// assumes bind onto ascg_top, one clock domain
`timescale 1ns/10ps
`include "ascg_defines.vh"
module ascg_chk (
    // clock and reset
    input logic CLK,
    input logic SYS_RST,
    // register port
    input logic CE,
    input logic [7:0] ADDR,
    input logic [15:0] WDATA,
    input logic WR,
    // outputs watched
    input logic BASE_TICK,
    input logic ADC_TICK,
    input logic DAC_OSR_TICK,
    input logic REF_RATE_SELECT,
    input logic MONITOR_PIN,
    input logic MONITOR_OE,
    input logic OSC_POWER,
    input logic TSC_EXT_CLK,
    input logic ADC_WCLK_SEP,
    input logic ADC_WORD_CLOCK_PIN
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    a_base_pulse_gap: assert property (
        BASE_TICK |=> !BASE_TICK [*8]) else $error("base tick too close");
    a_adc_tick_pulse: assert property (
        ADC_TICK |=> !ADC_TICK) else $error("adc tick not a pulse");
    a_osr_tick_pulse: assert property (
        DAC_OSR_TICK |=> !DAC_OSR_TICK) else $error("osr tick not a pulse");
    a_ref_sel_follow: assert property (
        (CE && WR && ADDR == `ASCG_IDX_CTRL3) |-> ##2
        REF_RATE_SELECT == $past(WDATA[`ASCG_REF_SEL_BIT], 2))
        else $error("ref select not written");
    a_mon_en_follow: assert property (
        (CE && WR && ADDR == `ASCG_IDX_MON) |-> ##2
        MONITOR_OE == $past(WDATA[`ASCG_MON_EN_BIT], 2))
        else $error("monitor enable not written");
    a_mon_needs_oe: assert property (
        MONITOR_PIN |-> MONITOR_OE || $past(MONITOR_OE))
        else $error("monitor pin active while disabled");
    a_mon_needs_conv: assert property (
        MONITOR_PIN |-> !OSC_POWER || !$past(OSC_POWER))
        else $error("monitor pin active with converters off");
    a_tsc_osc_off: assert property (
        TSC_EXT_CLK |-> !OSC_POWER || !$past(OSC_POWER))
        else $error("oscillator on while touch clock external");
    a_sep_pin_quiet: assert property (
        !ADC_WCLK_SEP && !$past(ADC_WCLK_SEP) |-> !ADC_WORD_CLOCK_PIN)
        else $error("adc word clock pin active at equal rates");
endmodule
bind ascg_top ascg_chk u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .BASE_TICK(BASE_TICK),
    .ADC_TICK(ADC_TICK), .DAC_OSR_TICK(DAC_OSR_TICK),
    .REF_RATE_SELECT(REF_RATE_SELECT), .MONITOR_PIN(MONITOR_PIN),
    .MONITOR_OE(MONITOR_OE), .OSC_POWER(OSC_POWER),
    .TSC_EXT_CLK(TSC_EXT_CLK), .ADC_WCLK_SEP(ADC_WCLK_SEP),
    .ADC_WORD_CLOCK_PIN(ADC_WORD_CLOCK_PIN));

// ==== testbench/test_audio_sample_clock_generator.sv ====
// self-checking bench for the audio sample clock generator
// assumes the checker binds itself; master clock is CLK/4
`timescale 1ns/10ps
`include "ascg_defines.vh"
module test_audio_sample_clock_generator;
    logic CLK = 1'b0, SYS_RST = 1'b1, CE = 1'b1, WR = 1'b0, RD = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [15:0] WDATA = 16'h0000, RDATA, v;
    logic MCLK_IN, BCLK_IN, BASE_TICK, DAC_TICK, ADC_TICK, DAC_OSR_TICK;
    logic ADC_WORD_CLOCK_PIN, WORD_CLOCK, ADC_WCLK_SEP, MONITOR_PIN;
    logic MONITOR_OE, REF_RATE_SELECT, TSC_EXT_CLK, OSC_POWER;
    int err_total = 0, samples_checked = 0, n;
    int hv[8] = '{2, 3, 4, 6, 8, 10, 11, 12};
    logic [7:0] ra[8] = '{8'h00, 8'h06, 8'h1B, 8'h1C, 8'h22, 8'h30, 8'h31,
        8'h55};
    logic [15:0] rv[8] = '{`ASCG_RST_RATE, `ASCG_RST_CTRL3, `ASCG_RST_PLL1,
        `ASCG_RST_PLL2, `ASCG_RST_MON, `ASCG_RST_CLKCTL, 16'h0002, 16'h0000};
    always #50 CLK = ~CLK;
    ascg_mclk_model #(.MCLK_HALF(200), .BCLK_HALF(332)) src (
        .mclk(MCLK_IN), .bclk(BCLK_IN));
    ascg_top dut (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .MCLK_IN(MCLK_IN),
        .BCLK_IN(BCLK_IN), .BASE_TICK(BASE_TICK), .DAC_TICK(DAC_TICK),
        .ADC_TICK(ADC_TICK), .DAC_OSR_TICK(DAC_OSR_TICK),
        .ADC_WORD_CLOCK_PIN(ADC_WORD_CLOCK_PIN), .WORD_CLOCK(WORD_CLOCK),
        .ADC_WCLK_SEP(ADC_WCLK_SEP), .MONITOR_PIN(MONITOR_PIN),
        .MONITOR_OE(MONITOR_OE), .REF_RATE_SELECT(REF_RATE_SELECT),
        .TSC_EXT_CLK(TSC_EXT_CLK), .OSC_POWER(OSC_POWER));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        @(negedge CLK);
        v = RDATA;
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: pick = BASE_TICK;
            1: pick = ADC_TICK;
            2: pick = DAC_TICK;
            3: pick = DAC_OSR_TICK;
            4: pick = MONITOR_PIN;
            6: pick = WORD_CLOCK;
            7: pick = ADC_WORD_CLOCK_PIN;
            default: pick = TSC_EXT_CLK;
        endcase
    endfunction
    // cycles between the second and third ticks, stale count skipped
    task automatic per(input int w);
        repeat (3) begin
            n = 0;
            do begin
                @(negedge CLK);
                n++;
            end while (pick(w) !== 1'b1 && n < 20000);
        end
    endtask
    task automatic tog(input int w);
        logic p;
        n = 0;
        p = pick(w);
        repeat (4096) begin
            @(negedge CLK);
            n += (pick(w) !== p);
            p = pick(w);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge CLK);
        SYS_RST <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(ra[i]);
            chk(v, rv[i]);
        end
        $display("reset values done");
        wr(8'h06, 16'h2000);
        rd(8'h06);
        chk({v[15:1], REF_RATE_SELECT}, 16'h2001);
        wr(8'h06, 16'h0000);
        rd(8'h06);
        chk({v[15:1], REF_RATE_SELECT}, 16'h0000);
        $display("rate family done");
        wr(8'h30, 16'h0102);
        repeat (2) @(negedge CLK);
        chk(OSC_POWER, 1'b0);
        per(0);
        chk(n, 16'd1024);
        per(3);
        chk(n, 16'd8);
        tog(5);
        chk(n > 0, 1'b1);
        wr(8'h30, 16'h0103);
        per(0);
        chk(n, 16'd1536);
        $display("bypass done");
        // fraction only written while bypassed: master clock is too slow
        wr(8'h1C, 16'h0004);
        rd(8'h1C);
        chk(v, 16'h0004);
        wr(8'h1C, 16'h0000);
        wr(8'h30, 16'h0002);
        // P 1, J 32: 80 MHz multiplied, base near 39 kHz
        wr(8'h1B, 16'h8080);
        wr(8'h30, 16'h0102);
        per(0);
        chk(n, 16'd256);
        rd(8'h1B);
        chk(v, 16'h8080);
        $display("pll done");
        wr(8'h22, 16'h0004);
        repeat (2) @(negedge CLK);
        chk(MONITOR_OE, 1'b1);
        tog(4);
        chk(n > 0, 1'b1);
        $display("monitor done");
        wr(8'h30, 16'h0302);
        for (int c = 0; c < 8; c++) begin
            wr(8'h00, 16'(c));
            per(1);
            chk(n, 16'(hv[c] * 128));
            chk(ADC_WCLK_SEP, c != 0);
        end
        tog(7);
        chk(n > 0, 1'b1);
        wr(8'h00, 16'h0020);
        per(2);
        chk(n, 16'd1024);
        tog(6);
        chk(n > 0, 1'b1);
        $display("dividers done");
        wr(8'h30, 16'h0002);
        repeat (8) @(posedge CLK);
        chk(OSC_POWER, 1'b1);
        tog(4);
        chk(n, 16'd0);
        tog(5);
        chk(n, 16'd0);
        $display("power down done");
        end_sim();
    end
    initial begin
        repeat (80000) @(posedge CLK);
        err_total++;
        end_sim();
    end
endmodule
